// file: cpu_core_model.sv
`timescale 1ns/10ps
// stand-in for the cpu side: answers vector fetches from a small rom
module cpu_core_model (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic rom_rd,
    input wire logic [7:0] rom_addr,
    output logic [7:0] rom_data
);
    logic [7:0] data_r; // last byte read from the rom
    logic [1:0] age_r; // cycles the byte still stands on the bus

    // byte follows the read by one cycle and stands two cycles
    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_r <= 8'h00;
            age_r <= 2'h0;
        end else if (rom_rd) begin
            // hi and lo of one vector always differ, so a swap shows
            data_r <= rom_addr ^ 8'h5a;
            age_r <= 2'h2;
        end else if (age_r != 2'h0) begin
            age_r <= age_r - 2'h1;
        end
    end

    // a stale byte is inverted so that a late sample cannot pass by luck
    assign rom_data = (age_r != 2'h0) ? data_r : ~data_r;
endmodule : cpu_core_model

// file: interrupt_request_and_vectoring.sv
`timescale 1ns/10ps
// What this block does
// - one request status bit per level
// - status register read-only, writes ignored
// - reset clears all request status bits
// - requests recorded while globally disabled
// - fixed source-to-level assignment
// - hardware flag set, request pulse, ack clears
// - timer overflows and counter a hardware-cleared
// - other sources stay pending until software clears
// - request, ack, vector, clear, then resume
// - service needs enable, mask, priority, source
// - acknowledge only at instruction end
// - entry clears enable, saves, then vectors
// - return sets global enable again
// - push pcl, pch, flags; fetch hi, lo
// - vectors even-aligned in lowest rom page
// - option bytes never used as vectors
// - priority register orders groups and levels
// - same level: lower vector address wins
module interrupt_request_and_vectoring import irq_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rd_data,
    input wire logic [7:0] hw_evt,
    input wire logic [7:0] sw_evt,
    input wire logic [7:0] sw_clr,
    input wire logic [7:0] src_en,
    input wire logic instr_end,
    input wire logic ei_exec,
    input wire logic di_exec,
    input wire logic return_from_handler_instruction_exec,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] flags_in,
    output logic acknowledge_strobe,
    output logic req_line,
    output logic stack_push,
    output logic [7:0] stack_data,
    output logic rom_rd,
    output logic [7:0] rom_addr,
    input wire logic [7:0] rom_data,
    output logic branch_valid,
    output logic [15:0] branch_addr,
    output logic global_enable_bit,
    output logic entry_busy
);
    top_state_t s_r; // registered state
    top_state_t s_nxt; // next state
    pend_t pend; // pending flags from the bank
    logic [7:0] req_status; // request status, hardware or software pending
    logic [7:0] qual_req; // levels unmasked with an enabled source
    grant_t grant; // winning level
    logic hw_pick; // winner is served through its hardware source
    logic take_ack; // acknowledge this cycle

    // flag storage; the ack clears the hardware flag of the served level
    pend_flag_bank u_pend (
        .core_clk(core_clk),
        .rst(rst),
        .hw_evt(hw_evt),
        .sw_evt(sw_evt),
        .sw_clr(sw_clr),
        .ack_valid(take_ack && hw_pick),
        .ack_level(grant.level),
        .pend(pend)
    );

    // status and qualification; recorded regardless of global enable
    assign req_status = (pend.hw & HW_CLEARED_LEVELS) | pend.sw;
    // sources live on fixed levels: 7..4 pins, 3 timer 2, 2 counter a, 1/0 timers
    assign qual_req = req_status & s_r.level_mask_register & src_en;

    // priority among the qualified levels
    level_priority_resolver u_prio (
        .req(qual_req),
        .prio(s_r.level_priority_register),
        .grant(grant)
    );

    // the hardware source has the lower vector address, so it wins its level
    assign hw_pick = pend.hw[grant.level] & HW_CLEARED_LEVELS[grant.level];
    // only between instructions, only when globally enabled and idle
    assign take_ack = (s_r.st == ST_IDLE) && instr_end && grant.valid &&
        s_r.system_mode_register[GE_BIT];

    // next-state logic for registers and the entry sequence
    always_comb begin
        s_nxt = s_r;
        s_nxt.branch_valid = 1'b0;
        s_nxt.req_pulse = |(hw_evt & HW_CLEARED_LEVELS);
        // register reads: one cycle latency, unmapped reads give zero
        if (reg_rd) begin
            case (reg_addr)
                ADDR_REQ_STATUS: s_nxt.rd_data = req_status;
                ADDR_LEVEL_MASK: s_nxt.rd_data = s_r.level_mask_register;
                ADDR_SYS_MODE: s_nxt.rd_data = s_r.system_mode_register;
                ADDR_LEVEL_PRIO: s_nxt.rd_data = s_r.level_priority_register;
                default: s_nxt.rd_data = 8'h00;
            endcase
        end
        // register writes; the status address has no write path
        if (reg_wr) begin
            case (reg_addr)
                ADDR_LEVEL_MASK: s_nxt.level_mask_register = reg_wdata;
                ADDR_SYS_MODE: s_nxt.system_mode_register = reg_wdata;
                ADDR_LEVEL_PRIO: s_nxt.level_priority_register = reg_wdata;
                default: s_nxt.rd_data = s_nxt.rd_data;
            endcase
        end
        // instruction effects on the global enable bit
        if (ei_exec || return_from_handler_instruction_exec) begin
            s_nxt.system_mode_register[GE_BIT] = 1'b1;
        end
        if (di_exec) begin
            s_nxt.system_mode_register[GE_BIT] = 1'b0;
        end
        // entry sequence
        case (s_r.st)
            ST_IDLE: begin
                if (take_ack) begin
                    // first disable further interrupts, then save state
                    s_nxt.system_mode_register[GE_BIT] = 1'b0;
                    s_nxt.level = grant.level;
                    s_nxt.vec_addr = (hw_pick ? HW_VEC_BASE : SW_VEC_BASE) +
                        {4'h0, grant.level, 1'b0};
                    s_nxt.pc_save = pc_in;
                    s_nxt.flags_save = flags_in;
                    s_nxt.stack_data = pc_in[7:0];
                    s_nxt.st = ST_PUSH_PCL;
                end
            end
            ST_PUSH_PCL: begin
                s_nxt.stack_data = s_r.pc_save[15:8];
                s_nxt.st = ST_PUSH_PCH;
            end
            ST_PUSH_PCH: begin
                s_nxt.stack_data = s_r.flags_save;
                s_nxt.st = ST_PUSH_FLG;
            end
            ST_PUSH_FLG: begin
                s_nxt.rom_addr = s_r.vec_addr;
                s_nxt.st = ST_FETCH_HI;
            end
            ST_FETCH_HI: begin
                // pairs are even aligned, so the low byte sits at addr | 1
                s_nxt.rom_addr = s_r.vec_addr | 8'h01;
                s_nxt.st = ST_FETCH_LO;
            end
            ST_FETCH_LO: begin
                s_nxt.vec_hi = rom_data; // high byte, one read latency
                s_nxt.st = ST_BRANCH;
            end
            ST_BRANCH: begin
                s_nxt.branch_addr = {s_r.vec_hi, rom_data};
                s_nxt.branch_valid = 1'b1;
                s_nxt.st = ST_IDLE;
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    // state register; mask and priority start cleared to keep things defined
    always_ff @(posedge core_clk) begin
        if (rst) begin
            s_r <= '0;
            s_r.st <= ST_IDLE;
            s_r.level_mask_register <= LEVEL_MASK_RESET;
            s_r.level_priority_register <= LEVEL_PRIO_RESET;
            s_r.system_mode_register <= SYS_MODE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs; push and fetch strobes decode the state, the ack strobe is combinational, data come from flops
    assign reg_rd_data = s_r.rd_data;
    assign acknowledge_strobe = take_ack;
    assign req_line = s_r.req_pulse;
    assign stack_push = (s_r.st == ST_PUSH_PCL) || (s_r.st == ST_PUSH_PCH) ||
        (s_r.st == ST_PUSH_FLG);
    assign stack_data = s_r.stack_data;
    assign rom_rd = (s_r.st == ST_FETCH_HI) || (s_r.st == ST_FETCH_LO);
    assign rom_addr = s_r.rom_addr;
    assign branch_valid = s_r.branch_valid;
    assign branch_addr = s_r.branch_addr;
    assign global_enable_bit = s_r.system_mode_register[GE_BIT];
    assign entry_busy = (s_r.st != ST_IDLE);

    // checks next to the logic
    a_reset_clears: assert property (@(posedge core_clk)
        rst |=> req_status == REQ_STATUS_RESET) else $error("status not cleared by reset");
    a_status_records: assert property (@(posedge core_clk) disable iff (rst)
        sw_evt != 8'h00 |=> (req_status & $past(sw_evt)) == $past(sw_evt))
        else $error("request not recorded");
    a_ack_at_end: assert property (@(posedge core_clk) disable iff (rst)
        acknowledge_strobe |-> instr_end && !entry_busy) else $error("ack mid instruction");
    a_ack_qualified: assert property (@(posedge core_clk) disable iff (rst)
        acknowledge_strobe |-> global_enable_bit && s_r.level_mask_register[grant.level]
        && src_en[grant.level]) else $error("unqualified ack");
    a_entry_order: assert property (@(posedge core_clk) disable iff (rst)
        acknowledge_strobe |=> stack_push && stack_data == $past(pc_in[7:0], 1)
        ##1 stack_push ##1 stack_push ##1 rom_rd ##1 rom_rd ##2 branch_valid)
        else $error("entry sequence out of order");
    a_enable_cleared: assert property (@(posedge core_clk) disable iff (rst)
        acknowledge_strobe |=> !global_enable_bit [*6]) else $error("enable not cleared");
    a_vector_place: assert property (@(posedge core_clk) disable iff (rst)
        rom_rd |-> (rom_addr < OPT_BYTES_LO || rom_addr > OPT_BYTES_HI))
        else $error("vector in option bytes");
    a_vec_even: assert property (@(posedge core_clk) disable iff (rst)
        s_r.st == ST_FETCH_HI |-> !rom_addr[0]) else $error("odd vector address");
    a_return_from_handler_instruction_enable: assert property (@(posedge core_clk) disable iff (rst)
        return_from_handler_instruction_exec && !di_exec && !acknowledge_strobe |=> global_enable_bit)
        else $error("return left interrupts off");
    a_sw_holds: assert property (@(posedge core_clk) disable iff (rst)
        (pend.sw & ~sw_clr) != 8'h00 |=> (pend.sw & $past(pend.sw & ~sw_clr)) ==
        $past(pend.sw & ~sw_clr)) else $error("software flag lost");
    a_hw_cleared: assert property (@(posedge core_clk) disable iff (rst)
        acknowledge_strobe && hw_pick && grant.level == 3'h0 && !hw_evt[0]
        |=> !pend.hw[0]) else $error("hardware flag not cleared");
    a_req_pulse: assert property (@(posedge core_clk) disable iff (rst)
        hw_evt[2] |=> req_line ##0 pend.hw[2]) else $error("no request pulse");
endmodule : interrupt_request_and_vectoring

// file: interrupt_request_and_vectoring_test.sv
`timescale 1ns/10ps
// register tasks, source pulses and full vectored entry walks
module interrupt_request_and_vectoring_test import irq_pkg::*;;
    logic core_clk; // 200 mhz
    logic rst; // synchronous, active high
    logic [7:0] reg_addr, reg_wdata, reg_rd_data, hw_evt, sw_evt, sw_clr, src_en;
    logic [7:0] flags_in, stack_data, rom_addr, rom_data;
    logic reg_wr, reg_rd, instr_end, ei_exec, di_exec, return_from_handler_instruction_exec;
    logic acknowledge_strobe, req_line, stack_push, rom_rd, branch_valid;
    logic global_enable_bit, entry_busy;
    logic [15:0] pc_in, branch_addr;
    int n_errors, checked, cycles; // counters

    interrupt_request_and_vectoring u_dut (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rd_data(reg_rd_data), .hw_evt(hw_evt), .sw_evt(sw_evt), .sw_clr(sw_clr),
        .src_en(src_en), .instr_end(instr_end), .ei_exec(ei_exec), .di_exec(di_exec),
        .return_from_handler_instruction_exec(return_from_handler_instruction_exec), .pc_in(pc_in), .flags_in(flags_in),
        .acknowledge_strobe(acknowledge_strobe), .req_line(req_line),
        .stack_push(stack_push), .stack_data(stack_data), .rom_rd(rom_rd),
        .rom_addr(rom_addr), .rom_data(rom_data), .branch_valid(branch_valid),
        .branch_addr(branch_addr), .global_enable_bit(global_enable_bit),
        .entry_busy(entry_busy));

    cpu_core_model u_cpu (.core_clk(core_clk), .rst(rst), .rom_rd(rom_rd),
        .rom_addr(rom_addr), .rom_data(rom_data));

    // clock generator
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // hang guard, far above the roughly 180 cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : wrap_up

    // one comparison, case equality so an unknown only matches an unknown
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // register write; idle cycle after so strobes never toggle twice at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    // register read, data lands the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        chk(reg_rd_data, exp);
    endtask : rd_chk

    // one-cycle source pulses; request line follows hardware sources only
    task automatic evt(input logic [7:0] hw, input logic [7:0] sw, input logic [7:0] clr);
        @(negedge core_clk);
        hw_evt = hw;
        sw_evt = sw;
        sw_clr = clr;
        @(negedge core_clk);
        hw_evt = 8'h00;
        sw_evt = 8'h00;
        sw_clr = 8'h00;
        chk(req_line, |hw[3:0]);
    endtask : evt

    // enable-related instruction pulses, then the resulting enable level
    task automatic op(input logic ei, input logic di, input logic return_from_handler_instruction, input logic ge);
        @(negedge core_clk);
        ei_exec = ei;
        di_exec = di;
        return_from_handler_instruction_exec = return_from_handler_instruction;
        @(negedge core_clk);
        ei_exec = 1'b0;
        di_exec = 1'b0;
        return_from_handler_instruction_exec = 1'b0;
        chk(global_enable_bit, ge);
    endtask : op

    // instruction end that must not be acknowledged
    task automatic no_ack();
        @(negedge core_clk);
        instr_end = 1'b1;
        #1 chk(acknowledge_strobe, 1'b0);
        @(negedge core_clk);
        instr_end = 1'b0;
    endtask : no_ack

    // whole entry walk: ack, three pushes, two fetches, branch
    task automatic enter(input logic [7:0] vec, input logic [15:0] pc, input logic [7:0] fl);
        logic [7:0] pushed [3];
        pushed = '{pc[7:0], pc[15:8], fl};
        @(negedge core_clk);
        instr_end = 1'b1;
        pc_in = pc;
        flags_in = fl;
        #1 chk(acknowledge_strobe, 1'b1);
        for (int k = 1; k <= 8; k++) begin
            @(negedge core_clk);
            instr_end = 1'b0;
            chk(acknowledge_strobe, 1'b0);
            chk(branch_valid, k == 7);
            if (k == 1) chk(global_enable_bit, 1'b0);
            chk(entry_busy, k < 7);
            if (k <= 3) begin
                chk(stack_push, 1'b1);
                chk(stack_data, pushed[k-1]);
            end
            if (k == 4 || k == 5) begin
                chk(rom_rd, 1'b1);
                chk(rom_addr, {vec[7:1], k == 5});
                chk(rom_addr[7:2] == 6'h0f, 1'b0);
            end
            if (k == 7) chk(branch_addr, {vec ^ 8'h5a, {vec[7:1], 1'b1} ^ 8'h5a});
        end
    endtask : enter

    // main sequence
    initial begin
        n_errors = 0;
        checked = 0;
        cycles = 0;
        rst = 1'b1;
        {reg_addr, reg_wdata, hw_evt, sw_evt, sw_clr, src_en, flags_in} = '0;
        {reg_wr, reg_rd, instr_end, ei_exec, di_exec, return_from_handler_instruction_exec} = '0;
        pc_in = 16'h0000;
        repeat (5) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        // reset values, then an unmapped address
        rd_chk(ADDR_REQ_STATUS, REQ_STATUS_RESET);
        rd_chk(ADDR_LEVEL_MASK, LEVEL_MASK_RESET);
        rd_chk(ADDR_SYS_MODE, SYS_MODE_RESET);
        rd_chk(ADDR_LEVEL_PRIO, LEVEL_PRIO_RESET);
        rd_chk(8'h80, 8'h00);
        // requests while disabled; upper hardware bits have no source
        evt(8'hf1, 8'h20, 8'h00);
        rd_chk(ADDR_REQ_STATUS, 8'h21);
        wr(ADDR_REQ_STATUS, 8'hff);
        rd_chk(ADDR_REQ_STATUS, 8'h21);
        no_ack();
        // unmask all, enable sources and globally
        wr(ADDR_LEVEL_MASK, 8'hff);
        src_en = 8'hff;
        wr(ADDR_SYS_MODE, 8'h01);
        rd_chk(ADDR_SYS_MODE, 8'h01);
        enter(8'h00, 16'h1234, 8'ha5);
        rd_chk(ADDR_REQ_STATUS, 8'h20);
        no_ack();
        op(1'b0, 1'b0, 1'b1, 1'b1);
        enter(8'h1a, 16'hbeef, 8'h3c);
        rd_chk(ADDR_REQ_STATUS, 8'h20);
        evt(8'h00, 8'h00, 8'h20);
        rd_chk(ADDR_REQ_STATUS, 8'h00);
        // level mask, then source enable, each hold a request back
        wr(ADDR_LEVEL_MASK, 8'hfd);
        op(1'b1, 1'b0, 1'b0, 1'b1);
        evt(8'h02, 8'h00, 8'h00);
        no_ack();
        wr(ADDR_LEVEL_MASK, 8'hff);
        src_en = 8'hfd;
        no_ack();
        src_en = 8'hff;
        enter(8'h02, 16'h0400, 8'h01);
        op(1'b1, 1'b1, 1'b0, 1'b0);
        // group order c over b over a
        wr(ADDR_LEVEL_PRIO, 8'h82);
        evt(8'h04, 8'h40, 8'h00);
        op(1'b0, 1'b0, 1'b1, 1'b1);
        enter(8'h1c, 16'h2000, 8'h00);
        evt(8'h00, 8'h00, 8'h40);
        op(1'b0, 1'b0, 1'b1, 1'b1);
        enter(8'h04, 16'h2002, 8'hff);
        // same level: hardware source before software source
        evt(8'h08, 8'h08, 8'h00);
        op(1'b0, 1'b0, 1'b1, 1'b1);
        enter(8'h06, 16'h3000, 8'h11);
        op(1'b0, 1'b0, 1'b1, 1'b1);
        enter(8'h16, 16'h3002, 8'h22);
        rd_chk(ADDR_REQ_STATUS, 8'h08);
        evt(8'h00, 8'h00, 8'h08);
        rd_chk(ADDR_REQ_STATUS, 8'h00);
        // nesting: save mask, open only group c, re-enable, then restore
        rd_chk(ADDR_LEVEL_MASK, 8'hff);
        wr(ADDR_LEVEL_MASK, 8'he0);
        evt(8'h01, 8'h40, 8'h00);
        op(1'b1, 1'b0, 1'b0, 1'b1);
        enter(8'h1c, 16'h4000, 8'h33);
        evt(8'h00, 8'h00, 8'h40);
        op(1'b0, 1'b0, 1'b1, 1'b1);
        no_ack();
        wr(ADDR_LEVEL_MASK, 8'hff);
        op(1'b0, 1'b0, 1'b1, 1'b1);
        enter(8'h00, 16'h4002, 8'h44);
        rd_chk(ADDR_REQ_STATUS, 8'h00);
        wrap_up();
    end
endmodule : interrupt_request_and_vectoring_test

// file: irq_pkg.sv
package irq_pkg;
    // register file addresses
    localparam logic [7:0] ADDR_REQ_STATUS = 8'hdc;
    localparam logic [7:0] ADDR_LEVEL_MASK = 8'hdd;
    localparam logic [7:0] ADDR_SYS_MODE = 8'hde;
    localparam logic [7:0] ADDR_LEVEL_PRIO = 8'hff;
    // reset values
    localparam logic [7:0] REQ_STATUS_RESET = 8'h00;
    localparam logic [7:0] LEVEL_MASK_RESET = 8'h00;
    localparam logic [7:0] LEVEL_PRIO_RESET = 8'h00;
    localparam logic [7:0] SYS_MODE_RESET = 8'h00;
    // global enable bit inside the system mode register
    localparam int GE_BIT = 0;
    // levels whose overflow or borrow source is cleared by hardware
    localparam logic [7:0] HW_CLEARED_LEVELS = 8'h0f;
    // vector table: even-aligned pairs in the lowest page, clear of 003ch..003fh
    localparam logic [7:0] HW_VEC_BASE = 8'h00;
    localparam logic [7:0] SW_VEC_BASE = 8'h10;
    localparam logic [7:0] OPT_BYTES_LO = 8'h3c;
    localparam logic [7:0] OPT_BYTES_HI = 8'h3f;
    // priority register field positions
    localparam int PRIO_A_BIT = 0;
    localparam int PRIO_G0_BIT = 1;
    localparam int PRIO_B_TOP_BIT = 2;
    localparam int PRIO_B_SUB_BIT = 3;
    localparam int PRIO_G1_BIT = 4;
    localparam int PRIO_C_TOP_BIT = 5;
    localparam int PRIO_C_SUB_BIT = 6;
    localparam int PRIO_G2_BIT = 7;

    // vectored entry sequence, gray coded from idle to branch
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PUSH_PCL = 3'b001,
        ST_PUSH_PCH = 3'b011,
        ST_PUSH_FLG = 3'b010,
        ST_FETCH_HI = 3'b110,
        ST_FETCH_LO = 3'b111,
        ST_BRANCH = 3'b101
    } entry_state_t;

    // pending flags of both kinds, one bit per level
    typedef struct packed {
        logic [7:0] hw;
        logic [7:0] sw;
    } pend_t;

    // winner of priority resolution
    typedef struct packed {
        logic valid;
        logic [2:0] level;
    } grant_t;

    // whole state of the top block
    typedef struct packed {
        entry_state_t st;
        logic [7:0] level_mask_register;
        logic [7:0] level_priority_register;
        logic [7:0] system_mode_register;
        logic [7:0] rd_data;
        logic [2:0] level;
        logic [7:0] vec_addr;
        logic [15:0] pc_save;
        logic [7:0] flags_save;
        logic [7:0] stack_data;
        logic [7:0] rom_addr;
        logic [7:0] vec_hi;
        logic [15:0] branch_addr;
        logic branch_valid;
        logic req_pulse;
    } top_state_t;
endpackage : irq_pkg

// file: level_priority_resolver.sv
`timescale 1ns/10ps
// picks the highest-priority requesting level from the priority register
module level_priority_resolver import irq_pkg::*; (
    input wire logic [7:0] req,
    input wire logic [7:0] prio,
    output grant_t grant
);
    grant_t win_a; // group a winner (levels 0,1)
    grant_t win_b; // group b winner (levels 2..4)
    grant_t win_c; // group c winner (levels 5..7)
    logic [2:0] order; // group ordering code

    // resolve inside each group, then order the groups
    always_comb begin
        win_a = '0;
        win_b = '0;
        win_c = '0;
        grant = '0;
        order = {prio[PRIO_G2_BIT], prio[PRIO_G1_BIT], prio[PRIO_G0_BIT]};
        // group a: one bit swaps levels 0 and 1
        if (req[0] && (!prio[PRIO_A_BIT] || !req[1])) win_a = '{1'b1, 3'h0};
        else if (req[1]) win_a = '{1'b1, 3'h1};
        // group b: subgroup 3/4, then level 2 against the subgroup
        if (req[3] && (!prio[PRIO_B_SUB_BIT] || !req[4])) win_b = '{1'b1, 3'h3};
        else if (req[4]) win_b = '{1'b1, 3'h4};
        if (req[2] && (!prio[PRIO_B_TOP_BIT] || !win_b.valid)) win_b = '{1'b1, 3'h2};
        // group c: subgroup 6/7, then level 5 against the subgroup
        if (req[6] && (!prio[PRIO_C_SUB_BIT] || !req[7])) win_c = '{1'b1, 3'h6};
        else if (req[7]) win_c = '{1'b1, 3'h7};
        if (req[5] && (!prio[PRIO_C_TOP_BIT] || !win_c.valid)) win_c = '{1'b1, 3'h5};
        // undefined codes fall back to a > b > c
        case (order)
            3'b001: grant = win_b.valid ? win_b : (win_c.valid ? win_c : win_a);
            3'b011: grant = win_b.valid ? win_b : (win_a.valid ? win_a : win_c);
            3'b100: grant = win_c.valid ? win_c : (win_a.valid ? win_a : win_b);
            3'b101: grant = win_c.valid ? win_c : (win_b.valid ? win_b : win_a);
            3'b110: grant = win_a.valid ? win_a : (win_c.valid ? win_c : win_b);
            default: grant = win_a.valid ? win_a : (win_b.valid ? win_b : win_c);
        endcase
    end
endmodule : level_priority_resolver

// file: pend_flag_bank.sv
`timescale 1ns/10ps
// holds the pending flags; set always beats clear in the same cycle
module pend_flag_bank import irq_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] hw_evt,
    input wire logic [7:0] sw_evt,
    input wire logic [7:0] sw_clr,
    input wire logic ack_valid,
    input wire logic [2:0] ack_level,
    output pend_t pend
);
    pend_t state_r; // registered flags
    pend_t state_nxt; // next flags
    logic [7:0] hw_nxt; // per-level hardware flag next value
    logic [7:0] sw_nxt; // per-level software flag next value

    // one slice per level
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_level
            // only the overflow and borrow levels own a hardware flag
            assign hw_nxt[i] = HW_CLEARED_LEVELS[i] & (hw_evt[i] |
                (state_r.hw[i] & ~(ack_valid & (ack_level == 3'(i)))));
            // software flag drops only on the handler's write of zero
            assign sw_nxt[i] = sw_evt[i] | (state_r.sw[i] & ~sw_clr[i]);
        end
    endgenerate

    // pack next state
    always_comb begin
        state_nxt.hw = hw_nxt;
        state_nxt.sw = sw_nxt;
    end

    // register state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pend = state_r;
endmodule : pend_flag_bank
